// ==== bench/data_memory_bank_indirect_addressing_tb.sv ====
`timescale 1ns/1ps
module data_memory_bank_indirect_addressing_tb;
   logic              clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, wdt_pd_reset_i = 1'b0;
   logic              alu_we_i = 1'b0, pc_advance_i = 1'b0, pc_jump_o, dummy_cycle_o, bank_sel_o;
   logic [7:0]        alu_result_i = 8'h00, pc_next_low_i = 8'h00, ext_rdata_i, rdata_o, accum_o, pc_low_o;
   dmb_pkg::dmb_req_t req_i = '0;
   dmb_pkg::dmb_mem_t ext_o, last_wr;
   int                fails = 0, check_count = 0;
   always #5 clk_i = ~clk_i;
   dmb_core i_dmb_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .wdt_pd_reset_i(wdt_pd_reset_i),
      .req_i(req_i), .alu_we_i(alu_we_i), .alu_result_i(alu_result_i), .pc_advance_i(pc_advance_i),
      .pc_next_low_i(pc_next_low_i), .ext_rdata_i(ext_rdata_i), .rdata_o(rdata_o), .ext_o(ext_o),
      .accum_o(accum_o), .pc_low_o(pc_low_o), .pc_jump_o(pc_jump_o), .dummy_cycle_o(dummy_cycle_o),
      .bank_sel_o(bank_sel_o));
   dmb_far_model i_dmb_far_model (.clk_i(clk_i), .req_i(req_i), .ext_i(ext_o), .ext_rdata_o(ext_rdata_i),
      .last_wr_o(last_wr));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // One idle cycle between accesses keeps each request edge distinct
   task automatic acc(input logic r, input logic w, input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1 req_i = '{r, w, a, d};
      @(posedge clk_i);
      #1 req_i = '0;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      acc(1'b0, 1'b1, a, d);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      acc(1'b1, 1'b0, a, 8'h00);
      chk(rdata_o, exp);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_indirect;
      chk({7'h00, bank_sel_o}, 8'h00);
      rd(7'h04, 8'h00);
      wr(7'h01, 8'h40);
      wr(7'h00, 8'ha5);
      rd(7'h40, 8'ha5);
      rd(7'h01, 8'h40);
      wr(7'h7f, 8'h5a);
      rd(7'h7f, 8'h5a);
      $display("indirect test done");
   endtask
   task automatic t_bank;
      wr(7'h04, 8'hff);
      rd(7'h04, 8'h01);
      chk({7'h00, bank_sel_o}, 8'h01);
      wr(7'h41, 8'h66);
      rd(7'h41, 8'h66);
      rd(7'h40, 8'ha5);
      rd(7'h00, 8'ha5);
      wr(7'h03, 8'h40);
      rd(7'h02, 8'h82);
      chk(ext_o.addr, 8'hc0);
      chk({6'h00, ext_o.rd, ext_o.wr}, 8'h02);
      wr(7'h02, 8'h3c);
      chk({6'h00, ext_o.wr, ext_o.addr[7]}, 8'h03);
      rd(7'h2e, 8'h00);
      chk(last_wr.wdata, 8'h3c);
      wr(7'h03, 8'h01);
      rd(7'h02, 8'h40);
      wr(7'h03, 8'h41);
      rd(7'h02, 8'h00);
      $display("bank test done");
   endtask
   task automatic t_self;
      wr(7'h04, 8'h00);
      rd(7'h41, 8'h66);
      wr(7'h03, 8'h02);
      rd(7'h02, 8'h00);
      wr(7'h03, 8'h00);
      wr(7'h02, 8'h77);
      rd(7'h40, 8'ha5);
      rd(7'h01, 8'h40);
      $display("self target test done");
   endtask
   task automatic t_pcl_alu;
      wr(7'h06, 8'h33);
      chk({pc_jump_o, 7'h00}, 8'h80);
      chk(pc_low_o, 8'h33);
      @(posedge clk_i);
      #1 chk({dummy_cycle_o, pc_jump_o, 6'h00}, 8'h80);
      alu_we_i = 1'b1;
      alu_result_i = 8'h9c;
      pc_advance_i = 1'b1;
      pc_next_low_i = 8'h34;
      @(posedge clk_i);
      #1 alu_we_i = 1'b0;
      pc_advance_i = 1'b0;
      chk({dummy_cycle_o, 7'h00}, 8'h00);
      chk(pc_low_o, 8'h34);
      chk(accum_o, 8'h9c);
      rd(7'h05, 8'h9c);
      rd(7'h7f, 8'h5a);
      wr(7'h05, rdata_o);
      wr(7'h42, accum_o);
      rd(7'h42, 8'h5a);
      $display("pcl alu test done");
   endtask
   task automatic t_freeze;
      @(posedge clk_i);
      #1 ce_i = 1'b0;
      req_i = '{1'b0, 1'b1, 7'h01, 8'h99};
      alu_we_i = 1'b1;
      alu_result_i = 8'h11;
      @(posedge clk_i);
      #1 ce_i = 1'b1;
      req_i = '0;
      alu_we_i = 1'b0;
      chk(accum_o, 8'h5a);
      rd(7'h01, 8'h40);
      $display("clock enable test done");
   endtask
   task automatic t_wdt;
      wr(7'h04, 8'h01);
      @(posedge clk_i);
      #1 rst_n_i = 1'b0;
      wdt_pd_reset_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      wdt_pd_reset_i = 1'b0;
      chk({7'h00, bank_sel_o}, 8'h01);
      rd(7'h03, 8'h00);
      @(posedge clk_i);
      #1 rst_n_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      chk({7'h00, bank_sel_o}, 8'h00);
      rd(7'h04, 8'h00);
      $display("wdt reset test done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      t_indirect();
      t_bank();
      t_self();
      t_pcl_alu();
      t_freeze();
      t_wdt();
      end_of_test();
   end
endmodule

// ==== bench/dmb_far_model.sv ====
`timescale 1ns/1ps
module dmb_far_model
(
   input  wire logic              clk_i,
   input  wire dmb_pkg::dmb_req_t req_i,
   input  wire dmb_pkg::dmb_mem_t ext_i,
   output logic [7:0]             ext_rdata_o,
   output dmb_pkg::dmb_mem_t      last_wr_o
);
   // Idle bus outside 2Eh..3Fh shows an inverted pattern so a stale sample never matches
   wire logic unused_w = req_i.addr inside {[7'h2e:7'h3f]};
   assign ext_rdata_o = unused_w ? 8'h00 : (req_i.rd ? {1'b1, req_i.addr} : {1'b0, ~req_i.addr});
   always_ff @(posedge clk_i)
   begin
      if (ext_i.wr)
         last_wr_o <= ext_i;
   end
endmodule

// ==== src/dmb_core.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Indirect port accesses are redirected to the address in the matching pointer.
// - Port zero reaches bank 0; port one reaches bank chosen by bank select bit.
// - Indirect access to an indirect port reads zero and writes nothing.
// - Both memory pointers are ordinary read/write storage registers.
// - Direct accesses always go to bank 0.
// - Bank pointer bit 0 selects bank 0 or bank 1.
// - Bank bit resets to 0, except watchdog reset during power-down keeps it.
// - Bank pointer bits 7..1 read as zero.
// - Unused special addresses 2Eh..3Fh go to the external bus and read whatever it returns.
// - Writing program counter low loads low byte, jumping within current page.
// - Such a jump inserts one dummy instruction cycle.
// - Accumulator receives ALU intermediate results.
// - Special registers appear in every bank; EEPROM control at 40h only in bank 1.
// - 64-byte general RAM at 40h..7Fh of bank 0, fully read/write.
module dmb_core
(
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   input  wire logic             wdt_pd_reset_i,
   input  wire dmb_pkg::dmb_req_t req_i,
   input  wire logic             alu_we_i,
   input  wire logic [7:0]       alu_result_i,
   input  wire logic             pc_advance_i,
   input  wire logic [7:0]       pc_next_low_i,
   input  wire logic [7:0]       ext_rdata_i,
   output logic [7:0]            rdata_o,
   output dmb_pkg::dmb_mem_t     ext_o,
   output logic [7:0]            accum_o,
   output logic [7:0]            pc_low_o,
   output logic                  pc_jump_o,
   output logic                  dummy_cycle_o,
   output logic                  bank_sel_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] mp0_r, mp1_r, acc_r, pcl_r, rdata_r;
   logic       bank_r, jump_r, dummy_r;
   logic [7:0] gpr_r [64];
   dmb_pkg::dmb_mem_t ext_r;

   wire ind0   = req_i.addr == dmb_pkg::ADDR_IND_PORT_0;
   wire ind1   = req_i.addr == dmb_pkg::ADDR_IND_PORT_1;
   wire is_ind = ind0 | ind1;
   // Effective address: bank bit above pointer, pointer zero forced to bank 0
   wire [7:0] ptr      = ind1 ? mp1_r : mp0_r;
   wire       eff_bank = ind1 ? bank_r : 1'b0;
   wire [6:0] eff_addr = is_ind ? ptr[6:0] : req_i.addr;
   // Pointer bit 7 hits nothing mapped in this 128-byte bank
   wire       ptr_hi   = is_ind & ptr[7];
   wire       eff_port = is_ind & ((eff_addr == dmb_pkg::ADDR_IND_PORT_0)
                                 | (eff_addr == dmb_pkg::ADDR_IND_PORT_1));
   wire       kill     = eff_port | ptr_hi;
   wire       sfr      = eff_addr <= dmb_pkg::ADDR_SFR_LAST;
   wire       gpr_hit  = ~sfr & ~eff_bank & ~kill;
   wire       eec_hit  = eff_bank & (eff_addr == dmb_pkg::ADDR_EEC) & ~kill;
   wire       ext_hit  = (sfr & ~kill & (eff_addr > dmb_pkg::ADDR_PC_LOW)) | eec_hit;
   wire       loc_hit  = sfr & ~kill;
   wire       wr_mp0   = req_i.wr & loc_hit & (eff_addr == dmb_pkg::ADDR_MEM_PTR_0);
   wire       wr_mp1   = req_i.wr & loc_hit & (eff_addr == dmb_pkg::ADDR_MEM_PTR_1);
   wire       wr_bank  = req_i.wr & loc_hit & (eff_addr == dmb_pkg::ADDR_BANK_SEL);
   wire       wr_acc   = req_i.wr & loc_hit & (eff_addr == dmb_pkg::ADDR_ACCUM);
   wire       wr_pcl   = req_i.wr & loc_hit & (eff_addr == dmb_pkg::ADDR_PC_LOW);
   wire       wr_gpr   = req_i.wr & gpr_hit;
   wire [5:0] gidx     = eff_addr[5:0];

   logic [7:0] rd_nxt;
   always_comb
   begin
      rd_nxt = dmb_pkg::READ_ZERO;
      if (gpr_hit)
         rd_nxt = gpr_r[gidx];
      else if (ext_hit)
         rd_nxt = ext_rdata_i;
      else if (loc_hit)
      begin
         unique case (eff_addr)
            dmb_pkg::ADDR_MEM_PTR_0: rd_nxt = mp0_r;
            dmb_pkg::ADDR_MEM_PTR_1: rd_nxt = mp1_r;
            dmb_pkg::ADDR_BANK_SEL:  rd_nxt = {7'h00, bank_r};
            dmb_pkg::ADDR_ACCUM:     rd_nxt = acc_r;
            dmb_pkg::ADDR_PC_LOW:    rd_nxt = pcl_r;
            default:                 rd_nxt = dmb_pkg::READ_ZERO;
         endcase
      end
   end

   dmb_pkg::dmb_mem_t ext_nxt;
   always_comb
   begin
      ext_nxt.rd    = req_i.rd & ext_hit;
      ext_nxt.wr    = req_i.wr & ext_hit;
      ext_nxt.addr  = {eff_bank, eff_addr};
      ext_nxt.wdata = req_i.wdata;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         mp0_r   <= dmb_pkg::PTR_RST;
         mp1_r   <= dmb_pkg::PTR_RST;
         acc_r   <= dmb_pkg::ACCUM_RST;
         pcl_r   <= dmb_pkg::PC_LOW_RST;
         rdata_r <= dmb_pkg::READ_ZERO;
         jump_r  <= 1'b0;
         dummy_r <= 1'b0;
         ext_r   <= '0;
      end
      else if (ce_i)
      begin
         rdata_r <= rd_nxt;
         ext_r   <= ext_nxt;
         if (wr_mp0) mp0_r <= req_i.wdata;
         if (wr_mp1) mp1_r <= req_i.wdata;
         if (wr_acc) acc_r <= req_i.wdata;
         else if (alu_we_i) acc_r <= alu_result_i;
         if (wr_pcl) pcl_r <= req_i.wdata;
         else if (pc_advance_i) pcl_r <= pc_next_low_i;
         jump_r  <= wr_pcl;
         dummy_r <= jump_r;
      end
   end

   // Bank bit has its own reset so a watchdog wake from power-down keeps it
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i && !wdt_pd_reset_i)
         bank_r <= dmb_pkg::BANK_SEL_RST;
      else if (rst_n_i && ce_i && wr_bank)
         bank_r <= req_i.wdata[dmb_pkg::BANK_BIT_POS];
   end

   // RAM is not reset; contents are volatile and undefined at power-up
   always_ff @(posedge clk_i)
   begin
      if (rst_n_i && ce_i && wr_gpr)
         gpr_r[gidx] <= req_i.wdata;
   end

   assign rdata_o       = rdata_r;
   assign ext_o         = ext_r;
   assign accum_o       = acc_r;
   assign pc_low_o      = pcl_r;
   assign pc_jump_o     = jump_r;
   assign dummy_cycle_o = dummy_r;
   assign bank_sel_o    = bank_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks look one cycle after the request edge, where the registered answer stands
   sequence s_pcl_write;
      ce_i && wr_pcl;
   endsequence
   sequence s_jump_then_dummy;
      pc_jump_o ##1 dummy_cycle_o;
   endsequence

   chk_ind_port_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.rd && is_ind && eff_port |=> rdata_o == dmb_pkg::READ_ZERO)
      else $error("indirect port read through pointer not zero");
   chk_ind_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.wr && eff_port && !alu_we_i && !pc_advance_i
      |=> $stable(mp0_r) && $stable(mp1_r) && $stable(acc_r) && $stable(pcl_r) && $stable(bank_sel_o))
      else $error("indirect write to port changed state");
   chk_ram_indirect: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.rd && !req_i.wr && ind0 && mp0_r[7:6] == 2'h1
      |=> rdata_o == gpr_r[$past(mp0_r[5:0])])
      else $error("indirect read did not return pointed memory");

   chk_direct_bank0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.wr && !is_ind && req_i.addr > dmb_pkg::ADDR_PC_LOW |=> ext_o.addr[7] == 1'b0)
      else $error("direct access left bank 0");
   chk_direct_ram: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.wr && !is_ind && req_i.addr >= dmb_pkg::ADDR_GPR_FIRST
      |=> gpr_r[$past(req_i.addr[5:0])] == $past(req_i.wdata))
      else $error("direct write missed bank 0 memory");
   chk_ptr0_bank0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && ind0 && (req_i.rd || req_i.wr) |=> ext_o.addr == {1'b0, $past(mp0_r[6:0])})
      else $error("pointer zero access not in bank 0");
   chk_ptr1_bank: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && ind1 && (req_i.rd || req_i.wr) |=> ext_o.addr == {$past(bank_r), $past(mp1_r[6:0])})
      else $error("pointer one address wrong");
   chk_ptr_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.wr && req_i.addr == dmb_pkg::ADDR_MEM_PTR_1 |=> mp1_r == $past(req_i.wdata))
      else $error("pointer one did not store written value");
   chk_bank1_unmapped: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.rd && ind1 && bank_sel_o && mp1_r > {1'h0, dmb_pkg::ADDR_EEC} && !mp1_r[7]
      |=> rdata_o == dmb_pkg::READ_ZERO)
      else $error("bank 1 address without register not zero");

   chk_bank_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.wr && req_i.addr == dmb_pkg::ADDR_BANK_SEL
      |=> bank_sel_o == $past(req_i.wdata[dmb_pkg::BANK_BIT_POS]))
      else $error("bank bit did not follow write");
   chk_bank_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.rd && !is_ind && req_i.addr == dmb_pkg::ADDR_BANK_SEL |=> rdata_o == {7'h00, bank_sel_o})
      else $error("bank pointer upper bits not zero");
   chk_bank_reset: assert property (@(posedge clk_i)
      !rst_n_i && !wdt_pd_reset_i |=> bank_sel_o == dmb_pkg::BANK_SEL_RST)
      else $error("bank bit not cleared by reset");

   chk_pcl_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.wr && req_i.addr == dmb_pkg::ADDR_PC_LOW |=> pc_low_o == $past(req_i.wdata))
      else $error("program counter low missed write");
   chk_pcl_jump: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_pcl_write ##1 ce_i |-> s_jump_then_dummy)
      else $error("dummy cycle missing after jump");
   chk_dummy_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && dummy_cycle_o && !pc_jump_o |=> !dummy_cycle_o)
      else $error("dummy cycle lasted more than one cycle");
   chk_acc_alu: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && alu_we_i && !wr_acc |=> accum_o == $past(alu_result_i))
      else $error("accumulator missed ALU result");

   // Clock enable low must hold every register, outputs included
   chk_freeze_state: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !ce_i |=> $stable(mp0_r) && $stable(mp1_r) && $stable(acc_r) && $stable(pcl_r) && $stable(bank_sel_o)
                && $stable(rdata_o) && $stable(ext_o) && $stable(pc_jump_o) && $stable(dummy_cycle_o))
      else $error("state moved while clock enable was low");
endmodule

// ==== src/dmb_pkg.sv ====
package dmb_pkg;
   localparam logic [6:0] ADDR_IND_PORT_0 = 7'h00;
   localparam logic [6:0] ADDR_MEM_PTR_0  = 7'h01;
   localparam logic [6:0] ADDR_IND_PORT_1 = 7'h02;
   localparam logic [6:0] ADDR_MEM_PTR_1  = 7'h03;
   localparam logic [6:0] ADDR_BANK_SEL   = 7'h04;
   localparam logic [6:0] ADDR_ACCUM      = 7'h05;
   localparam logic [6:0] ADDR_PC_LOW     = 7'h06;
   localparam logic [6:0] ADDR_SFR_LAST   = 7'h3f;
   localparam logic [6:0] ADDR_EEC        = 7'h40;
   localparam logic [6:0] ADDR_GPR_FIRST  = 7'h40;
   localparam int         BANK_BIT_POS    = 0;
   localparam logic       BANK_SEL_RST    = 1'b0;
   localparam logic [7:0] ACCUM_RST       = 8'h00;
   localparam logic [7:0] PTR_RST         = 8'h00;
   localparam logic [7:0] PC_LOW_RST      = 8'h00;
   localparam logic [7:0] READ_ZERO       = 8'h00;

   // Access request from the execution unit
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } dmb_req_t;

   // Access toward special registers 07h..3Fh and EEPROM control (RAM stays internal); bank in bit 7 of addr
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dmb_mem_t;
endpackage
